/* File: core/cycle_divider.sv */
// instruction cycle divider: one enable pulse per group of oscillator periods.
// assumes i_mclk is the oscillator clock and i_run comes from the same domain.
`timescale 1ns/10ps
`default_nettype none

module cycle_divider
	import decode_pkg::*;
	#(
	parameter int PERIODS = OSC_PER_CYCLE
	)
	(
	// clock and reset
	input  wire logic  i_mclk,
	input  wire logic  i_reset,
	// control
	input  wire logic  i_run,
	// instruction cycle pulse
	output var  logic  o_cyc_en
	);

	localparam int CW = (PERIODS > 1) ? $clog2(PERIODS) : 1;
	localparam logic [CW-1:0] LAST = CW'(PERIODS - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          en;
	} div_s;

	div_s st_reg;
	div_s st_next;

	always_comb
	begin
		st_next = st_reg;
		st_next.en = 1'b0;
		if (!i_run)
		begin
			st_next.cnt = '0;
		end
		else if (st_reg.cnt == LAST)
		begin
			st_next.cnt = '0;
			st_next.en = 1'b1;
		end
		else
		begin
			st_next.cnt = CW'(st_reg.cnt + 1'b1);
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign o_cyc_en = st_reg.en;

endmodule
`default_nettype wire

/* File: core/decode_pkg.sv */
// package for the instruction decoder: field positions, opcode groups,
// register map and the structs that carry the bus and the decoded word.
// assumes a 16-bit program memory and a 32-bit apb register bus.
package decode_pkg;

	////////////////////////////////////////////////////////////////////
	// word and timing
	localparam int WORD_W        = 16;
	localparam int OSC_PER_CYCLE = 4;
	localparam int CNT_W         = 32;

	////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] CTRL_OFS    = 12'h000;
	localparam logic [ADDR_W-1:0] STATUS_OFS  = 12'h004;
	localparam logic [ADDR_W-1:0] CYCLES_OFS  = 12'h008;
	localparam logic [ADDR_W-1:0] LAST_LO_OFS = 12'h00C;
	localparam logic [ADDR_W-1:0] LAST_HI_OFS = 12'h010;
	localparam int CTRL_RUN_BIT    = 0;
	localparam int CTRL_EXT_BIT    = 1;
	localparam int STAT_SECOND_BIT = 0;
	localparam int STAT_TAKEN_BIT  = 1;
	localparam int STAT_RUN_BIT    = 2;
	localparam int STAT_EXT_BIT    = 3;

	////////////////////////////////////////////////////////////////////
	// operand field positions
	localparam int HI_MSB  = 15;
	localparam int HI_LSB  = 12;
	localparam int SUB_MSB = 11;
	localparam int SUB_LSB = 8;
	localparam int F_MSB   = 7;
	localparam int A_POS   = 8;
	localparam int D_POS   = 9;
	localparam int B_MSB   = 11;
	localparam int B_LSB   = 9;
	localparam int FSR_MSB = 5;
	localparam int FSR_LSB = 4;
	localparam int KH_MSB  = 3;
	localparam int S_POS   = 0;
	localparam int MM_MSB  = 1;
	localparam int NS_MSB  = 10;
	localparam int N2_MSB  = 11;
	localparam int K_W     = 12;
	localparam int N_W     = 20;
	localparam logic [7:0] BIT_ONE = 8'h01;

	////////////////////////////////////////////////////////////////////
	// opcode groups
	localparam logic [3:0] SECOND_TAG = 4'hF;
	localparam logic [3:0] HI_ZERO    = 4'h0;
	localparam logic [3:0] HI_BIT_LO  = 4'h7;
	localparam logic [3:0] HI_BIT_HI  = 4'hB;
	localparam logic [3:0] HI_BRANCH  = 4'hD;
	localparam logic [3:0] HI_LONG    = 4'hE;
	localparam logic [3:0] SUB_ZERO   = 4'h0;
	localparam logic [3:0] SUB_BANK   = 4'h1;
	localparam logic [3:0] SUB_LIT_LO = 4'hE;
	localparam logic [3:0] SUB_EXT_LO = 4'h8;
	localparam logic [3:0] SUB_EXT_HI = 4'hB;
	localparam logic [3:0] SUB_PTR    = 4'hE;
	localparam int DW_COUNT = 4;
	localparam logic [DW_COUNT-1:0][15:0] DW_MASK  =
		{16'hF000, 16'hFE00, 16'hFF00, 16'hFFC0};
	localparam logic [DW_COUNT-1:0][15:0] DW_MATCH =
		{16'hC000, 16'hEC00, 16'hEF00, 16'hEE00};
	localparam logic [15:0] EXT_MASK   = 16'hFC00;
	localparam logic [15:0] EXT_MATCH  = 16'hE800;
	localparam logic [15:0] EXT_SINGLE = 16'h0014;

	////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {CAT_BYTE, CAT_BIT, CAT_LIT, CAT_CTRL} cat_e;

	typedef struct packed {
		cat_e               cat;
		logic               dw;
		logic               nop;
		logic               ext;
		logic [WORD_W-1:0]  w0;
		logic [WORD_W-1:0]  w1;
		logic [7:0]         f;
		logic               d;
		logic               a;
		logic [2:0]         bitn;
		logic [7:0]         bitsel;
		logic [K_W-1:0]     k;
		logic [1:0]         indirect_pointer_reg;
		logic [N_W-1:0]     n;
		logic               s;
		logic [1:0]         mm;
		logic               wr_acc;
		logic               wr_file;
		logic               use_bank;
		logic               shadow;
	} dec_s;

	typedef struct packed {
		logic               psel;
		logic               penable;
		logic               pwrite;
		logic [ADDR_W-1:0]  paddr;
		logic [DATA_W-1:0]  pwdata;
	} apb_req_s;

	typedef struct packed {
		logic               pready;
		logic [DATA_W-1:0]  prdata;
		logic               pslverr;
	} apb_rsp_s;

endpackage

/* File: core/mcu_instruction_decode_timing.sv */
// instruction decoder and cycle sequencer of an 8-bit core.
// assumes program memory presents the requested word on i_pm_word before
// the next cycle pulse, and the execution unit reports flow changes on the
// same clock.
`timescale 1ns/10ps
`default_nettype none

module mcu_instruction_decode_timing
	import decode_pkg::*;
	#(
	parameter int PERIODS = OSC_PER_CYCLE
	)
	(
	// clock and reset
	input  wire logic               i_mclk,
	input  wire logic               i_reset,
	// register bus
	input  wire apb_req_s           i_apb,
	output var  apb_rsp_s           o_apb,
	// program memory fetch
	input  wire logic [WORD_W-1:0]  i_pm_word,
	output var  logic               o_fetch,
	// execution unit
	input  wire logic               i_flow_taken,
	output var  logic               o_cyc_en,
	output var  logic               o_issue,
	output var  dec_s               o_dec
	);

	typedef enum logic [1:0] {PH_STOP, PH_FIRST, PH_SECOND} ph_e;

	typedef struct packed {
		ph_e                ph;
		logic               run;
		logic               ext_en;
		logic               taken;
		logic               fetch;
		logic               issue;
		logic [WORD_W-1:0]  hold;
		logic [CNT_W-1:0]   cycles;
		dec_s               dec;
		apb_rsp_s           rsp;
	} st_s;

	st_s  st_reg;
	st_s  st_next;
	logic cyc_en;

	////////////////////////////////////////////////////////////////////
	// opcode classification

	function automatic cat_e classify(input logic [WORD_W-1:0] w);
		logic [3:0] hi;
		logic [3:0] sub;
		cat_e       c;
		hi = w[HI_MSB:HI_LSB];
		sub = w[SUB_MSB:SUB_LSB];
		c = CAT_BYTE;
		if (hi == HI_ZERO)
		begin
			if (sub == SUB_ZERO)
				c = CAT_CTRL;
			else if (sub == SUB_BANK || sub >= SUB_LIT_LO)
				c = CAT_LIT;
		end
		else if (hi >= HI_BIT_LO && hi <= HI_BIT_HI)
		begin
			c = CAT_BIT;
		end
		else if (hi == HI_BRANCH || hi == SECOND_TAG)
		begin
			c = CAT_CTRL;
		end
		else if (hi == HI_LONG)
		begin
			if ((sub >= SUB_EXT_LO && sub <= SUB_EXT_HI) || sub == SUB_PTR)
				c = CAT_LIT;
			else
				c = CAT_CTRL;
		end
		return c;
	endfunction

	function automatic logic is_double(input logic [WORD_W-1:0] w);
		logic r;
		r = 1'b0;
		for (int i = 0; i < DW_COUNT; i++)
		begin
			if ((w & DW_MASK[i]) == DW_MATCH[i])
				r = 1'b1;
		end
		return r;
	endfunction

	function automatic logic is_ext(input logic [WORD_W-1:0] w);
		return ((w & EXT_MASK) == EXT_MATCH) || (w == EXT_SINGLE);
	endfunction

	////////////////////////////////////////////////////////////////////
	// operand extraction

	function automatic dec_s build(
		input logic [WORD_W-1:0] w0,
		input logic [WORD_W-1:0] w1,
		input logic              dw,
		input logic              ext_en
	);
		dec_s d;
		d = '0;
		d.w0 = w0;
		d.w1 = w1;
		d.dw = dw;
		d.ext = is_ext(w0);
		d.cat = classify(w0);
		// lone second word, or extended opcode while the group is off
		d.nop = (!dw && w0[HI_MSB:HI_LSB] == SECOND_TAG)
			|| (d.ext && !ext_en);
		case (d.cat)
			CAT_BYTE:
			begin
				d.f = w0[F_MSB:0];
				d.d = w0[D_POS];
				d.a = w0[A_POS];
				d.wr_acc = !w0[D_POS];
				d.wr_file = w0[D_POS];
				d.use_bank = w0[A_POS];
				if (dw)
					d.n = {w1[N2_MSB:0], w0[F_MSB:0]};
			end
			CAT_BIT:
			begin
				d.f = w0[F_MSB:0];
				d.a = w0[A_POS];
				d.bitn = w0[B_MSB:B_LSB];
				d.bitsel = BIT_ONE << w0[B_MSB:B_LSB];
				d.use_bank = w0[A_POS];
			end
			CAT_LIT:
			begin
				d.indirect_pointer_reg = w0[FSR_MSB:FSR_LSB];
				if (dw)
					d.k = {w0[KH_MSB:0], w1[F_MSB:0]};
				else
					d.k = K_W'(w0[F_MSB:0]);
			end
			CAT_CTRL:
			begin
				d.s = w0[S_POS];
				d.mm = w0[MM_MSB:0];
				d.shadow = w0[S_POS];
				if (dw)
					d.n = {w1[N2_MSB:0], w0[F_MSB:0]};
				else
					d.n = N_W'(w0[NS_MSB:0]);
			end
			default:
			begin
				d.nop = 1'b1;
			end
		endcase
		if (d.nop)
		begin
			d.wr_acc = 1'b0;
			d.wr_file = 1'b0;
			d.shadow = 1'b0;
		end
		return d;
	endfunction

	function automatic dec_s idle_cycle(input logic [WORD_W-1:0] w);
		dec_s d;
		d = '0;
		d.cat = CAT_CTRL;
		d.nop = 1'b1;
		d.w0 = w;
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////
	// register read mux

	function automatic logic [DATA_W-1:0] read_reg(
		input st_s               s,
		input logic [ADDR_W-1:0] addr
	);
		logic [DATA_W-1:0] r;
		r = '0;
		case (addr)
			CTRL_OFS:
			begin
				r[CTRL_RUN_BIT] = s.run;
				r[CTRL_EXT_BIT] = s.ext_en;
			end
			STATUS_OFS:
			begin
				r[STAT_SECOND_BIT] = (s.ph == PH_SECOND);
				r[STAT_TAKEN_BIT] = s.taken;
				r[STAT_RUN_BIT] = (s.ph != PH_STOP);
				r[STAT_EXT_BIT] = s.dec.ext;
			end
			CYCLES_OFS:  r = s.cycles;
			LAST_LO_OFS: r = DATA_W'(s.dec.w0);
			LAST_HI_OFS: r = DATA_W'(s.dec.w1);
			default:     r = '0;
		endcase
		return r;
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] addr);
		return addr == CTRL_OFS || addr == STATUS_OFS || addr == CYCLES_OFS
			|| addr == LAST_LO_OFS || addr == LAST_HI_OFS;
	endfunction

	////////////////////////////////////////////////////////////////////
	// instruction cycle pulse

	cycle_divider #(
		.PERIODS (PERIODS)
	) u_div (
		.i_mclk   (i_mclk),
		.i_reset  (i_reset),
		.i_run    (st_reg.run),
		.o_cyc_en (cyc_en)
	);

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		logic access;
		logic done;
		logic flush;
		access = i_apb.psel && i_apb.penable;
		done = access && st_reg.rsp.pready;
		flush = st_reg.taken || i_flow_taken;
		st_next = st_reg;
		st_next.issue = 1'b0;
		st_next.fetch = 1'b0;
		st_next.rsp = '0;

		// a flow change is held until the next cycle boundary consumes it
		st_next.taken = flush;

		// apb: one wait state, write lands at the completing edge
		if (access && !st_reg.rsp.pready)
		begin
			st_next.rsp.pready = 1'b1;
			st_next.rsp.prdata = read_reg(st_reg, i_apb.paddr);
			st_next.rsp.pslverr = !mapped(i_apb.paddr);
		end

		if (!st_reg.run)
		begin
			st_next.ph = PH_STOP;
			st_next.taken = 1'b0;
		end
		else if (st_reg.ph == PH_STOP)
		begin
			st_next.ph = PH_FIRST;
			st_next.fetch = 1'b1;
		end
		else if (cyc_en)
		begin
			st_next.taken = 1'b0;
			st_next.fetch = 1'b1;
			st_next.cycles = CNT_W'(st_reg.cycles + 1'b1);
			if (flush)
			begin
				// prefetched word dropped, this cycle runs as a nop
				st_next.issue = 1'b1;
				st_next.dec = idle_cycle(i_pm_word);
				st_next.ph = PH_FIRST;
			end
			else
			begin
				case (st_reg.ph)
					PH_FIRST:
					begin
						if (is_double(i_pm_word))
						begin
							// first half only; issued with its partner
							st_next.hold = i_pm_word;
							st_next.ph = PH_SECOND;
						end
						else
						begin
							st_next.issue = 1'b1;
							st_next.dec = build(i_pm_word, '0, 1'b0,
								st_reg.ext_en);
						end
					end
					PH_SECOND:
					begin
						st_next.issue = 1'b1;
						st_next.dec = build(st_reg.hold, i_pm_word, 1'b1,
							st_reg.ext_en);
						st_next.ph = PH_FIRST;
					end
					default:
					begin
						st_next.ph = PH_FIRST;
					end
				endcase
			end
		end

		if (done && i_apb.pwrite && i_apb.paddr == CTRL_OFS)
		begin
			st_next.run = i_apb.pwdata[CTRL_RUN_BIT];
			st_next.ext_en = i_apb.pwdata[CTRL_EXT_BIT];
			if (!i_apb.pwdata[CTRL_RUN_BIT])
			begin
				st_next.ph = PH_STOP;
				st_next.issue = 1'b0;
				st_next.fetch = 1'b0;
			end
		end
		else if (done && i_apb.pwrite && i_apb.paddr == CYCLES_OFS)
		begin
			st_next.cycles = i_apb.pwdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign o_apb = st_reg.rsp;
	assign o_fetch = st_reg.fetch;
	assign o_cyc_en = cyc_en;
	assign o_issue = st_reg.issue;
	assign o_dec = st_reg.dec;

endmodule
`default_nettype wire

/* File: sim/decode_checker.sv */
// checker: cycle spacing, issue timing and operand routing at the ports.
// assumes it is bound into mcu_instruction_decode_timing.
`timescale 1ns/10ps
`default_nettype none

module decode_checker
	import decode_pkg::*;
	#(
	parameter int PERIODS = OSC_PER_CYCLE
	)
	(
	// clock and reset
	input  wire logic               i_mclk,
	input  wire logic               i_reset,
	// watched ports
	input  wire logic [WORD_W-1:0]  i_pm_word,
	input  wire logic               i_flow_taken,
	input  wire logic               o_cyc_en,
	input  wire logic               o_issue,
	input  wire dec_s               o_dec
	);
	int   gap_reg;
	logic armed_reg;

	always_ff @(posedge i_mclk or posedge i_reset)
		if (i_reset)
		begin
			gap_reg   <= 0;
			armed_reg <= 1'b0;
		end
		else
		begin
			gap_reg   <= o_cyc_en ? 0 : gap_reg + 1;
			armed_reg <= armed_reg | o_cyc_en;
		end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	////////////////////////////////////////////////////////////////////
	a_cycle_period: assert property (o_cyc_en && armed_reg |-> gap_reg == PERIODS - 1)
		else $error("cycle pulse spacing wrong");
	a_issue_pulse: assert property (o_issue |-> $past(o_cyc_en) ##1 !o_issue)
		else $error("issue not one pulse after cycle");
	a_lone_second: assert property (o_issue && !o_dec.dw && o_dec.w0[15:12] == SECOND_TAG
		|-> o_dec.nop) else $error("lone second word not nop");
	a_flow_nop: assert property (o_issue && $past(i_flow_taken) && $past(o_cyc_en)
		|-> o_dec.nop) else $error("taken flow not followed by nop");
	a_dw_pair: assert property (o_issue && o_dec.dw |-> o_dec.w1 == $past(i_pm_word)
		&& o_dec.w0 == $past(i_pm_word, PERIODS + 1)) else $error("double word halves wrong");
	a_dw_two_cycles: assert property (o_issue && o_dec.dw |-> $past(o_cyc_en, PERIODS + 1))
		else $error("double word not two cycles");
	a_dest_route: assert property (o_issue && o_dec.cat == CAT_BYTE && !o_dec.nop
		&& !o_dec.dw |-> o_dec.wr_file == o_dec.d && o_dec.wr_acc == !o_dec.d)
		else $error("destination routing wrong");
	a_bank_route: assert property (o_issue && o_dec.cat != CAT_LIT && o_dec.cat != CAT_CTRL
		&& !o_dec.nop && !o_dec.dw |-> o_dec.use_bank == o_dec.a) else $error("bank select wrong");
	a_bit_onehot: assert property (o_issue && o_dec.cat == CAT_BIT
		|-> o_dec.bitsel == BIT_ONE << o_dec.bitn) else $error("bit select wrong");
	a_fast_shadow: assert property (o_issue && o_dec.cat == CAT_CTRL && !o_dec.nop
		|-> o_dec.shadow == o_dec.s) else $error("shadow use wrong");
endmodule

bind mcu_instruction_decode_timing decode_checker #(.PERIODS(PERIODS)) i_decode_checker (
	.i_mclk(i_mclk), .i_reset(i_reset), .i_pm_word(i_pm_word), .i_flow_taken(i_flow_taken),
	.o_cyc_en(o_cyc_en), .o_issue(o_issue), .o_dec(o_dec));
`default_nettype wire

/* File: sim/pm_model.sv */
// program memory model: presents the next stored word after each fetch.
// assumes the bench loads mem before the sequencer runs.
`timescale 1ns/10ps
`default_nettype none

module pm_model
	import decode_pkg::*;
	(
	// clock and reset
	input  wire logic               i_mclk,
	input  wire logic               i_reset,
	// fetch port
	input  wire logic               i_fetch,
	output var  logic [WORD_W-1:0]  o_word
	);
	logic [WORD_W-1:0] mem [0:15];
	logic [3:0]        ptr_reg;

	always_ff @(posedge i_mclk or posedge i_reset)
		if (i_reset)
		begin
			ptr_reg <= 4'h0;
			o_word  <= 16'h0000;
		end
		else if (i_fetch)
		begin
			o_word  <= mem[ptr_reg];
			ptr_reg <= ptr_reg + 4'h1;
		end
endmodule
`default_nettype wire

/* File: sim/test_mcu_instruction_decode_timing.sv */
// testbench: register access, then a short program through the decoder.
// assumes pm_model as program memory and four clocks per instruction cycle.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end

module test_mcu_instruction_decode_timing;
	import decode_pkg::*;
	localparam int P = OSC_PER_CYCLE;
	logic              i_mclk, i_reset, i_flow_taken, o_fetch, o_cyc_en, o_issue;
	logic [WORD_W-1:0] word;
	apb_req_s          req;
	apb_rsp_s          rsp;
	dec_s              dec;
	int                n_errors = 0;
	int                checked = 0;
	int                cycles = 0;

	mcu_instruction_decode_timing #(.PERIODS(P)) i_mcu_instruction_decode_timing (
		.i_mclk(i_mclk), .i_reset(i_reset), .i_apb(req), .o_apb(rsp), .i_pm_word(word),
		.o_fetch(o_fetch), .i_flow_taken(i_flow_taken), .o_cyc_en(o_cyc_en),
		.o_issue(o_issue), .o_dec(dec));
	pm_model i_pm_model (.i_mclk(i_mclk), .i_reset(i_reset), .i_fetch(o_fetch), .o_word(word));

	initial
	begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end

	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			finish_test();
		end
	end

	task finish_test();
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	task apb(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd,
		output logic [DATA_W-1:0] rd, output logic er);
		@(posedge i_mclk);
		req <= '{1'b1, 1'b0, wr, ad, wd};
		@(posedge i_mclk);
		req.penable <= 1'b1;
		// pready ends this wait; it has no limit of its own, so a stalled bus ends only at the bench timeout
		do
		begin
			@(posedge i_mclk);
		end
		while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask

	task next_issue();
		int n;
		n = 0;
		do
		begin
			@(negedge i_mclk);
			n++;
		end
		while (o_issue !== 1'b1 && n < 20);
		`CHK({o_issue, o_fetch}, 2'b11)
	endtask

	////////////////////////////////////////////////////////////////////
	task test_regs();
		logic [DATA_W-1:0] rd;
		logic              er;
		apb(1'b0, CTRL_OFS, '0, rd, er);
		`CHK(rd, 32'h0000_0000)
		apb(1'b0, 12'h020, '0, rd, er);
		`CHK({er, rd}, 33'h1_0000_0000)
	endtask

	task test_program();
		logic [DATA_W-1:0] rd;
		logic              er;
		i_pm_model.mem = '{16'h27A5, 16'h2C12, 16'h8B34, 16'hC123, 16'hF456, 16'hF0FF,
			16'h0E55, 16'h27A5, 16'hEF10, 16'hF002, 16'h0013, 16'hE812, 16'hE812,
			16'hE812, 16'hE812, 16'hE812};
		apb(1'b1, CTRL_OFS, 32'h0000_0003, rd, er);
		next_issue();
		`CHK({dec.cat, dec.f, dec.d, dec.a}, {CAT_BYTE, 8'hA5, 2'b11})
		`CHK({dec.wr_file, dec.wr_acc, dec.use_bank}, 3'b101)
		next_issue();
		`CHK({dec.f, dec.d, dec.a, dec.wr_acc, dec.use_bank}, {8'h12, 4'b0010})
		next_issue();
		`CHK({dec.cat, dec.f, dec.bitn, dec.a, dec.bitsel}, {CAT_BIT, 8'h34, 4'hB, 8'h20})
		next_issue();
		`CHK({dec.dw, dec.w0, dec.w1}, {1'b1, 16'hC123, 16'hF456})
		next_issue();
		`CHK({dec.dw, dec.nop}, 2'b01)
		next_issue();
		`CHK({dec.cat, dec.k, dec.indirect_pointer_reg}, {CAT_LIT, 12'h055, 2'b01})
		@(posedge i_mclk);
		i_flow_taken <= 1'b1;
		@(posedge i_mclk);
		i_flow_taken <= 1'b0;
		next_issue();
		`CHK({dec.cat, dec.nop, dec.w0}, {CAT_CTRL, 1'b1, 16'h27A5})
		next_issue();
		`CHK({dec.cat, dec.dw, dec.n}, {CAT_CTRL, 1'b1, 20'h00210})
		next_issue();
		`CHK({dec.s, dec.shadow, dec.mm}, 4'hF)
		next_issue();
		`CHK({dec.cat, dec.ext, dec.nop, dec.indirect_pointer_reg, dec.k}, {CAT_LIT, 4'h9, 12'h012})
		apb(1'b0, STATUS_OFS, '0, rd, er);
		`CHK(rd[STAT_RUN_BIT], 1'b1)
		`CHK(rd[STAT_EXT_BIT], 1'b1)
		// extended group off: the word issued at the write's completing edge still decodes with it on, so the second issue is checked as a nop
		apb(1'b1, CTRL_OFS, 32'h0000_0001, rd, er);
		next_issue();
		next_issue();
		`CHK({dec.ext, dec.nop, dec.wr_acc, dec.wr_file}, 4'hC)
	endtask

	initial
	begin
		i_reset = 1'b1;
		i_flow_taken = 1'b0;
		req = '0;
		repeat (6) @(posedge i_mclk);
		i_reset <= 1'b0;
		test_regs();
		test_program();
		finish_test();
	end
endmodule
`default_nettype wire
